//--- core/vdl_serial_loader.sv
`timescale 1ns/100ps
`include "vdl_regs.svh"
module vdl_serial_loader (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Serial link pins
   input wire logic sclk,
   input wire logic sdata,
   input wire logic shift_sel_n,
   input wire logic latch_strobe_n,
   // Converter levels
   output logic [`VDL_MST_W-1:0] master_level,
   output logic master_mute,
   output logic [`VDL_NUM_CH*`VDL_CH_W-1:0] chan_level
);
   ////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for all pins
   logic [3:0] s1_ff;
   logic [3:0] s2_ff;
   logic sclk_d_ff;
   logic ld_d_ff;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s1_ff <= `VDL_PIN_IDLE;
         s2_ff <= `VDL_PIN_IDLE;
         sclk_d_ff <= 1'b1;
         ld_d_ff <= 1'b1;
      end else begin
         s1_ff <= {latch_strobe_n, shift_sel_n, sdata, sclk};
         s2_ff <= s1_ff;
         sclk_d_ff <= s2_ff[0];
         ld_d_ff <= s2_ff[3];
      end
   end

   wire sclk_s;
   wire data_s;
   wire sel_n_s;
   wire ld_s;
   assign sclk_s = s2_ff[0];
   assign data_s = s2_ff[1];
   assign sel_n_s = s2_ff[2];
   assign ld_s = s2_ff[3];

   wire sclk_fall;
   wire ld_rise;
   assign sclk_fall = sclk_d_ff && !sclk_s;
   assign ld_rise = !ld_d_ff && ld_s;

   ////////////////////////////////////////////////////////////////
   // Shift register
   logic [`VDL_BYTE_W-1:0] shreg_ff;
   logic [`VDL_BYTE_W-1:0] nxt_shreg;
   wire do_shift;
   assign do_shift = sclk_fall && !sel_n_s;
   assign nxt_shreg = do_shift ? {shreg_ff[`VDL_BYTE_W-2:0], data_s} : shreg_ff;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         shreg_ff <= `VDL_SHREG_RST;
      end else begin
         shreg_ff <= nxt_shreg;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Frame tracker
   // Strobe edges count only from the shift phase of an open frame
   wire frame_open;
   assign frame_open = !sel_n_s || !ld_s;
   vdl_pkg::vdl_state_t state_ff;
   vdl_pkg::vdl_state_t nxt_state;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         vdl_pkg::VDL_IDLE: begin
            if (frame_open) begin
               nxt_state = vdl_pkg::VDL_SHIFT;
            end
         end
         vdl_pkg::VDL_SHIFT: begin
            if (ld_rise) begin
               nxt_state = vdl_pkg::VDL_LOAD;
            end else if (!frame_open) begin
               nxt_state = vdl_pkg::VDL_IDLE;
            end
         end
         vdl_pkg::VDL_LOAD: begin
            if (frame_open) begin
               nxt_state = vdl_pkg::VDL_SHIFT;
            end else begin
               nxt_state = vdl_pkg::VDL_IDLE;
            end
         end
         default: begin
            nxt_state = vdl_pkg::VDL_IDLE;
         end
      endcase
   end

   logic [3:0] nbits_ff;
   logic [3:0] nxt_nbits;
   wire byte_full;
   wire ld_take;
   // Count saturates; extra clocks are legal and only push old bits out
   assign byte_full = (nbits_ff == 4'(`VDL_BYTE_W));
   assign nxt_nbits = !frame_open ? `VDL_NBITS_RST : ((do_shift && !byte_full) ? nbits_ff + 4'h1 : nbits_ff);
   assign ld_take = ld_rise && (state_ff == vdl_pkg::VDL_SHIFT);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_ff <= vdl_pkg::VDL_IDLE;
         nbits_ff <= `VDL_NBITS_RST;
      end else begin
         state_ff <= nxt_state;
         nbits_ff <= nxt_nbits;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Byte decode on latch edge
   // Only the last eight bits count; extra clocks just push old bits out
   wire is_addr;
   assign is_addr = shreg_ff[`VDL_MSB];
   logic [2:0] sel_ff;
   logic [2:0] nxt_sel;
   assign nxt_sel = (ld_take && is_addr) ? shreg_ff[`VDL_SEL_W-1:0] : sel_ff;
   logic wr_ff;
   logic nxt_wr;
   // Data goes to the last address; none selected after reset
   assign nxt_wr = ld_take && !is_addr && (sel_ff != `VDL_SEL_NONE);
   logic [`VDL_MST_W-1:0] code_ff;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sel_ff <= `VDL_SEL_NONE;
         wr_ff <= 1'b0;
         code_ff <= `VDL_CODE_RST;
      end else begin
         sel_ff <= nxt_sel;
         wr_ff <= nxt_wr;
         code_ff <= shreg_ff[`VDL_MST_W-1:0];
      end
   end

   vdl_hold_if hold ();
   assign hold.wr = wr_ff;
   assign hold.sel = sel_ff;
   assign hold.code = code_ff;

   vdl_hold_regs u_hold (
      .mclk(mclk),
      .rst_b(rst_b),
      .hold(hold),
      .master_level_ff(master_level),
      .mute_ff(master_mute),
      .chan_level_ff(chan_level)
   );

   ////////////////////////////////////////////////////////////////
   a_shift_gated: assert property (@(posedge mclk) disable iff (!rst_b)
      sel_n_s |=> shreg_ff == $past(shreg_ff))
      else $error("shift while deselected");
   a_shift_msb: assert property (@(posedge mclk) disable iff (!rst_b)
      do_shift |=> shreg_ff[0] == $past(data_s) && shreg_ff[7:1] == $past(shreg_ff[6:0]))
      else $error("shift order wrong");
   a_addr_sel: assert property (@(posedge mclk) disable iff (!rst_b)
      ld_rise && is_addr |=> sel_ff == $past(shreg_ff[2:0]) && !wr_ff)
      else $error("address not taken");
   a_data_wr: assert property (@(posedge mclk) disable iff (!rst_b)
      ld_rise && !is_addr && sel_ff != `VDL_SEL_NONE |=> wr_ff && code_ff == $past(shreg_ff[6:0]))
      else $error("data not written");
   a_wr_only_edge: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_ff |-> $past(ld_rise))
      else $error("write without latch edge");
   a_chan_write: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_ff && sel_ff == 3'h1 |=> chan_level[4:0] == $past(code_ff[4:0]))
      else $error("channel one not loaded");
   a_master_to_out: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_ff && sel_ff == `VDL_SEL_MASTER |=> master_level == $past(code_ff))
      else $error("master output wrong");
   a_reset_mute: assert property (@(posedge mclk)
      !rst_b |=> master_mute)
      else $error("mute not forced at reset");
   a_load_in_frame: assert property (@(posedge mclk) disable iff (!rst_b)
      ld_rise |-> state_ff == vdl_pkg::VDL_SHIFT)
      else $error("latch edge outside a frame");
   a_state_onehot: assert property (@(posedge mclk) disable iff (!rst_b)
      $onehot(state_ff))
      else $error("frame state not one-hot");
   a_wr_in_load: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_ff |-> state_ff == vdl_pkg::VDL_LOAD)
      else $error("write outside load phase");
   a_none_drop: assert property (@(posedge mclk) disable iff (!rst_b)
      ld_rise && !is_addr && sel_ff == `VDL_SEL_NONE |=>
      !wr_ff ##1 $stable(master_level) && $stable(chan_level) && $stable(master_mute))
      else $error("data after no-converter address was used");
   a_sel_persist: assert property (@(posedge mclk) disable iff (!rst_b)
      !ld_rise |=> $stable(sel_ff))
      else $error("selection changed without latch edge");
   a_mute_release: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_ff && sel_ff == `VDL_SEL_MASTER |=> !master_mute)
      else $error("mute not released by master write");
   a_mute_until_master: assert property (@(posedge mclk) disable iff (!rst_b)
      master_mute && !(wr_ff && sel_ff == `VDL_SEL_MASTER) |=> master_mute)
      else $error("mute released without master write");
   a_level_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      !wr_ff |=> $stable(master_level) && $stable(chan_level))
      else $error("levels moved without a write");

   genvar ci;
   generate
      for (ci = 1; ci <= `VDL_NUM_CH; ci = ci + 1) begin : g_chk
         a_chan_load: assert property (@(posedge mclk) disable iff (!rst_b)
            wr_ff && sel_ff == 3'(ci) |=> chan_level[(ci-1)*`VDL_CH_W +: `VDL_CH_W] == $past(code_ff[4:0]))
            else $error("channel level not loaded");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Coverage of the main scenarios
   c_addr_byte: cover property (@(posedge mclk) disable iff (!rst_b) ld_rise && is_addr);
   c_data_byte: cover property (@(posedge mclk) disable iff (!rst_b) wr_ff);
   c_none_data: cover property (@(posedge mclk) disable iff (!rst_b)
      ld_rise && !is_addr && sel_ff == `VDL_SEL_NONE);
   c_full_byte: cover property (@(posedge mclk) disable iff (!rst_b) ld_rise && byte_full);
endmodule : vdl_serial_loader

//--- core/vdl_regs.svh
// Contract
// - An update is an address byte followed by a data byte, eight bits each.
// - A byte with MSB one is an address byte selecting the target.
// - A byte with MSB zero is data for the last addressed converter.
// - Master takes seven low data bits; 7f is 0 dB, 00 is -127 dB.
// - Channels take five low bits, inverted gain; 1f is 0 dB, 00 is +31 dB.
// - Address low three bits: 0 master, 1..6 channels, 7 none; rest ignored.
// - Shifting happens only while the active-low shift select is low.
// - Holding register loads only on the rising edge of the latch strobe.
// - Bytes arrive MSB first, one bit per falling serial clock edge.
// - At reset the master mute is forced active until programmed.
`ifndef VDL_REGS_SVH
`define VDL_REGS_SVH
`define VDL_BYTE_W 8
`define VDL_MSB 7
`define VDL_MST_W 7
`define VDL_CH_W 5
`define VDL_NUM_CH 6
`define VDL_SEL_MASTER 3'h0
`define VDL_SEL_NONE 3'h7
`define VDL_MST_RST 7'h00
`define VDL_CH_RST 5'h1f
`define VDL_SEL_W 3
`define VDL_SHREG_RST 8'h00
`define VDL_CODE_RST 7'h00
`define VDL_PIN_IDLE 4'hf
`define VDL_NBITS_RST 4'h0
`endif

//--- core/vdl_pkg.sv
package vdl_pkg;
   typedef enum logic [2:0] {
      VDL_IDLE = 3'b001,
      VDL_SHIFT = 3'b010,
      VDL_LOAD = 3'b100
   } vdl_state_t;
endpackage : vdl_pkg

//--- core/vdl_hold_if.sv
`timescale 1ns/100ps
interface vdl_hold_if;
   logic wr;
   logic [2:0] sel;
   logic [6:0] code;
   modport src (output wr, output sel, output code);
   modport dst (input wr, input sel, input code);
endinterface : vdl_hold_if

//--- core/vdl_hold_regs.sv
`timescale 1ns/100ps
`include "vdl_regs.svh"
module vdl_hold_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Write side
   vdl_hold_if.dst hold,
   // Holding registers
   output logic [`VDL_MST_W-1:0] master_level_ff,
   output logic mute_ff,
   output logic [`VDL_NUM_CH*`VDL_CH_W-1:0] chan_level_ff
);
   wire wr_master;
   assign wr_master = hold.wr && (hold.sel == `VDL_SEL_MASTER);

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         master_level_ff <= `VDL_MST_RST;
         mute_ff <= 1'b1;
      end else if (wr_master) begin
         master_level_ff <= hold.code;
         mute_ff <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `VDL_NUM_CH; gi = gi + 1) begin : g_ch
         wire wr_ch;
         assign wr_ch = hold.wr && (hold.sel == 3'(gi + 1));
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               chan_level_ff[gi*`VDL_CH_W +: `VDL_CH_W] <= `VDL_CH_RST;
            end else if (wr_ch) begin
               chan_level_ff[gi*`VDL_CH_W +: `VDL_CH_W] <= hold.code[`VDL_CH_W-1:0];
            end
         end
      end
   endgenerate

   a_master_write: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_master |=> master_level_ff == $past(hold.code) && !mute_ff)
      else $error("master level not loaded");
   a_none_ignored: assert property (@(posedge mclk) disable iff (!rst_b)
      (!hold.wr || hold.sel == `VDL_SEL_NONE) |=> $stable(master_level_ff) && $stable(chan_level_ff))
      else $error("no-converter write changed levels");
   c_master_write: cover property (@(posedge mclk) disable iff (!rst_b) wr_master);
endmodule : vdl_hold_regs

//--- tb/vdl_ctrl_model.sv
`timescale 1ns/100ps
module vdl_ctrl_model (
   // Serial link pins
   output logic sclk,
   output logic sdata,
   output logic shift_sel_n,
   output logic latch_strobe_n
);
   initial begin
      sclk = 1'b1;
      sdata = 1'b0;
      shift_sel_n = 1'b1;
      latch_strobe_n = 1'b1;
   end
   // Sel low leaves shift select high but still pulses the strobe
   task automatic send_byte(input logic [7:0] b, input logic sel);
      shift_sel_n = ~sel;
      latch_strobe_n = 1'b0;
      // Odd offset keeps every pin change off a rising mclk edge
      #63.5;
      for (int i = 7; i >= 0; i--) begin
         sdata = b[i];
         #62.5 sclk = 1'b0;
         #62.5 sclk = 1'b1;
      end
      #62.5;
      shift_sel_n = 1'b1;
      latch_strobe_n = 1'b1;
      // Released line flips so a stale bit never looks valid
      sdata = ~sdata;
      #125;
   endtask : send_byte
endmodule : vdl_ctrl_model

//--- tb/test_volume_dac_serial_loader.sv
`timescale 1ns/100ps
`include "vdl_regs.svh"
module test_volume_dac_serial_loader;
   logic mclk, rst_b, sclk, sdata, shift_sel_n, latch_strobe_n, master_mute, exp_mute;
   logic [6:0] master_level, exp_mst;
   logic [29:0] chan_level, exp_ch;
   logic [2:0] exp_sel;
   logic [7:0] corner [8] = '{8'h80, 8'h7f, 8'h00, 8'h83, 8'h1f, 8'h10, 8'h00, 8'h0f};
   int failures, num_checks;
   integer seed;
   vdl_serial_loader DUT (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .sdata(sdata), .shift_sel_n(shift_sel_n),
      .latch_strobe_n(latch_strobe_n), .master_level(master_level), .master_mute(master_mute),
      .chan_level(chan_level));
   vdl_ctrl_model u_ctrl (.sclk(sclk), .sdata(sdata), .shift_sel_n(shift_sel_n),
      .latch_strobe_n(latch_strobe_n));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("failures=%0d num_checks=%0d", failures, num_checks);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic check_outputs;
      num_checks++;
      if (master_level !== exp_mst || master_mute !== exp_mute || chan_level !== exp_ch) begin
         failures++;
         $display("[FAIL] %0t got %h %b %h want %h %b %h", $time, master_level, master_mute, chan_level,
            exp_mst, exp_mute, exp_ch);
      end
   endtask : check_outputs
   // Expected channel word after one data byte to channel sel
   function automatic logic [29:0] chan_after(input logic [29:0] cur, input logic [2:0] sel, input logic [4:0] code);
      logic [29:0] r;
      r = cur;
      r[(int'(sel) - 1) * 5 +: 5] = code;
      return r;
   endfunction : chan_after
   // Sends one byte, updates the expected levels, checks after the load delay
   task automatic put_byte(input logic [7:0] b, input logic sel);
      u_ctrl.send_byte(b, sel);
      if (sel && b[7])
         exp_sel = b[2:0];
      else if (sel && exp_sel == 3'h0) begin
         exp_mst = b[6:0];
         exp_mute = 1'b0;
      end else if (sel && exp_sel != 3'h7)
         exp_ch = chan_after(exp_ch, exp_sel, b[4:0]);
      repeat (10) @(negedge mclk);
      check_outputs();
   endtask : put_byte
   ////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h701f;
      rst_b = 1'b0;
      exp_mst = `VDL_MST_RST;
      exp_ch = {6{`VDL_CH_RST}};
      exp_mute = 1'b1;
      exp_sel = `VDL_SEL_NONE;
      repeat (12) @(negedge mclk);
      check_outputs();
      rst_b = 1'b1;
      repeat (3) @(negedge mclk);
      put_byte(8'h15, 1'b1);
      for (int s = 0; s < 8; s++) begin
         put_byte({1'b1, 4'($random(seed)), 3'(s)}, 1'b1);
         put_byte({1'b0, 7'($random(seed))}, 1'b1);
         put_byte({1'b0, 7'($random(seed))}, 1'b1);
      end
      for (int i = 0; i < 3; i++)
         put_byte(corner[i], 1'b1);
      for (int i = 3; i < 8; i++)
         put_byte(corner[i], 1'b1);
      // Mid-run reset must mute again and forget the selection
      rst_b = 1'b0;
      repeat (4) @(negedge mclk);
      exp_mst = `VDL_MST_RST;
      exp_ch = {6{`VDL_CH_RST}};
      exp_mute = 1'b1;
      exp_sel = `VDL_SEL_NONE;
      check_outputs();
      rst_b = 1'b1;
      repeat (3) @(negedge mclk);
      put_byte(8'h2a, 1'b1);
      put_byte(8'h80, 1'b1);
      put_byte(8'h3a, 1'b0);
      put_byte(8'h5c, 1'b1);
      complete_run();
   end
   // Whole run needs about 50 us; ten times that means a hang
   initial begin
      #500000;
      failures++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
   end
endmodule : test_volume_dac_serial_loader
